//--- inc/sme_pkg.sv
/*
 * Constants for the shift/move/indirect-load execution slice: register map,
 * status field positions, instruction field positions, reset values, states.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package sme_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_W = 8'h04;
   localparam logic [7:0] OFF_STAT = 8'h08;
   localparam logic [7:0] OFF_PTR0 = 8'h0C;
   localparam logic [7:0] OFF_PTR1 = 8'h10;
   localparam logic [7:0] OFF_COUNT = 8'h14;
   // status fields
   localparam int STAT_C = 0;
   localparam int STAT_Z = 1;
   localparam int STAT_BUSY = 2;
   // instruction word fields
   localparam int CLS_HI = 13;
   localparam int CLS_LO = 12;
   localparam int DEST_BIT = 7;
   localparam int REL_BIT = 7;
   localparam int PTR_BIT = 6;
   localparam logic [1:0] CLS_NOP = 2'h0;
   localparam logic [1:0] CLS_SHIFT = 2'h1;
   localparam logic [1:0] CLS_MOVE = 2'h2;
   localparam logic [1:0] CLS_INDIR = 2'h3;
   // file addresses that alias the pointed-to location
   localparam logic [6:0] ALIAS0_ADDR = 7'h00;
   localparam logic [6:0] ALIAS1_ADDR = 7'h01;
   // reset values
   localparam logic [7:0] W_RST = 8'h00;
   localparam logic [15:0] PTR_RST = 16'h0000;
   localparam logic CTRL_EN_RST = 1'b1;
   typedef enum logic [1:0] {
      UPD_PREINC = 2'b00,
      UPD_PREDEC = 2'b01,
      UPD_POSTINC = 2'b10,
      UPD_POSTDEC = 2'b11
   } sme_upd_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_WRITE = 2'b10
   } sme_state_t;
endpackage : sme_pkg

//--- verilog/sme_exec.sv
/*
 * Execution slice: logical right shift, file move and indirect load with
 * two 16-bit pointers. Holds W, carry, zero and the pointers; reaches the
 * file/data memory through a request/acknowledge port on the same clock.
 * Assumes fetch presents one instruction word per instrValid and that
 * memory answers every request with memAck, data on memRdata.
 */
// Local design decisions: register access over APB and the address map.
//
// Behaviour
// - right shift: result is operand shifted down, zero on top, bit 0 to carry
// - right shift updates carry and zero, one bit per execution
// - destination bit clear sends the result to W
// - destination bit set writes result back to the 7-bit file address
// - file move copies file register to W or back to itself
// - file move sets zero from the moved value in both cases
// - update field: 00 preinc, 01 predec, 10 postinc, 11 postdec
// - relative form: address is pointer plus signed offset, pointer kept
// - after load pointer is plus one, minus one, or unchanged
// - alias address reads or writes the location the pointer names
// - pointers are 16 bits and wrap at both ends
// - pointer steps leave the flags alone; loaded value drives zero
`timescale 1ns/100ps
module sme_exec (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // instruction from fetch
   input wire logic instrValid,
   input wire logic [13:0] instrWord,
   output logic instrReady,
   output logic instrDone,
   // file and data memory
   output logic memReq,
   output logic memWe,
   output logic [15:0] memAddr,
   output logic [7:0] memWdata,
   input wire logic memAck,
   input wire logic [7:0] memRdata
);
   sme_pkg::sme_state_t stateQ, stateD;
   logic [1:0] clsQ, clsD;
   logic destQ, destD, selQ, selD, relQ, relD;
   logic [1:0] updQ, updD;
   logic [7:0] wQ, wD;
   logic carryQ, carryD, zeroQ, zeroD, enQ, enD;
   logic [15:0] ptrQ [2];
   logic [15:0] ptrD [2];
   logic [15:0] countQ, countD;
   logic reqQ, reqD, weQ, weD, doneQ, doneD;
   logic [15:0] addrQ, addrD;
   logic [7:0] wdataQ, wdataD;
   logic [31:0] rdataQ, rdataD;
   logic [7:0] res;
   logic accept, apbWr, apbSetup;

   // address the file operand names; alias addresses follow a pointer
   function automatic logic [15:0] fileAddr(input logic [6:0] f, input logic [15:0] p0,
                                            input logic [15:0] p1);
      if (f == sme_pkg::ALIAS0_ADDR) return p0;
      if (f == sme_pkg::ALIAS1_ADDR) return p1;
      return {9'h000, f};
   endfunction : fileAddr

   // effective address of an indirect load
   function automatic logic [15:0] effAddr(input logic [15:0] p, input logic rel,
                                           input logic [1:0] upd, input logic [5:0] k);
      if (rel) return p + {{10{k[5]}}, k};
      unique case (upd)
         sme_pkg::UPD_PREINC: return p + 16'h0001;
         sme_pkg::UPD_PREDEC: return p - 16'h0001;
         default: return p;
      endcase
   endfunction : effAddr

   function automatic logic mapped(input logic [7:0] a);
      return a == sme_pkg::OFF_CTRL || a == sme_pkg::OFF_W || a == sme_pkg::OFF_STAT ||
         a == sme_pkg::OFF_PTR0 || a == sme_pkg::OFF_PTR1 || a == sme_pkg::OFF_COUNT;
   endfunction : mapped

   assign instrReady = (stateQ == sme_pkg::ST_IDLE) && enQ;
   assign accept = instrValid && instrReady;
   assign pready = psel && penable;
   assign pslverr = psel && penable && !mapped(paddr);
   assign apbWr = psel && penable && pwrite && mapped(paddr);
   assign apbSetup = psel && !penable;
   assign prdata = rdataQ;
   assign memReq = reqQ;
   assign memWe = weQ;
   assign memAddr = addrQ;
   assign memWdata = wdataQ;
   assign instrDone = doneQ;

   always_comb begin
      stateD = stateQ;
      clsD = clsQ;
      destD = destQ;
      selD = selQ;
      relD = relQ;
      updD = updQ;
      wD = wQ;
      carryD = carryQ;
      zeroD = zeroQ;
      enD = enQ;
      ptrD = ptrQ;
      countD = countQ;
      reqD = reqQ;
      weD = weQ;
      addrD = addrQ;
      wdataD = wdataQ;
      doneD = 1'b0;
      rdataD = rdataQ;
      res = memRdata;
      // software writes first; execution updates below take priority
      if (apbWr) begin
         unique case (paddr)
            sme_pkg::OFF_CTRL: enD = pwdata[0];
            sme_pkg::OFF_W: wD = pwdata[7:0];
            sme_pkg::OFF_STAT: begin
               carryD = pwdata[sme_pkg::STAT_C];
               zeroD = pwdata[sme_pkg::STAT_Z];
            end
            sme_pkg::OFF_PTR0: ptrD[0] = pwdata[15:0];
            sme_pkg::OFF_PTR1: ptrD[1] = pwdata[15:0];
            default: ;
         endcase
      end
      if (apbSetup) begin
         unique case (paddr)
            sme_pkg::OFF_CTRL: rdataD = {31'h0, enQ};
            sme_pkg::OFF_W: rdataD = {24'h0, wQ};
            sme_pkg::OFF_STAT: rdataD = {29'h0, stateQ != sme_pkg::ST_IDLE, zeroQ, carryQ};
            sme_pkg::OFF_PTR0: rdataD = {16'h0, ptrQ[0]};
            sme_pkg::OFF_PTR1: rdataD = {16'h0, ptrQ[1]};
            sme_pkg::OFF_COUNT: rdataD = {16'h0, countQ};
            default: rdataD = 32'h0000_0000;
         endcase
      end
      unique case (stateQ)
         sme_pkg::ST_IDLE: begin
            if (accept) begin
               clsD = instrWord[sme_pkg::CLS_HI:sme_pkg::CLS_LO];
               destD = instrWord[sme_pkg::DEST_BIT];
               relD = instrWord[sme_pkg::REL_BIT];
               selD = instrWord[sme_pkg::PTR_BIT];
               updD = instrWord[1:0];
               if (clsD == sme_pkg::CLS_NOP) begin
                  doneD = 1'b1;
                  countD = countQ + 16'h0001;
               end else begin
                  reqD = 1'b1;
                  weD = 1'b0;
                  stateD = sme_pkg::ST_READ;
                  if (clsD == sme_pkg::CLS_INDIR) begin
                     addrD = effAddr(ptrQ[selD], relD, updD, instrWord[5:0]);
                  end else begin
                     addrD = fileAddr(instrWord[6:0], ptrQ[0], ptrQ[1]);
                  end
               end
            end
         end
         sme_pkg::ST_READ: begin
            if (memAck) begin
               reqD = 1'b0;
               if (clsQ == sme_pkg::CLS_SHIFT) begin
                  res = {1'b0, memRdata[7:1]};
                  carryD = memRdata[0];
               end
               zeroD = (res == 8'h00);
               if (clsQ == sme_pkg::CLS_INDIR && !relQ) begin
                  // pre and post steps wrap modulo 2^16 with no flag effect
                  ptrD[selQ] = updQ[0] ? ptrQ[selQ] - 16'h0001
                                       : ptrQ[selQ] + 16'h0001;
               end
               if (destQ && clsQ != sme_pkg::CLS_INDIR) begin
                  reqD = 1'b1;
                  weD = 1'b1;
                  wdataD = res;
                  stateD = sme_pkg::ST_WRITE;
               end else begin
                  wD = res;
                  doneD = 1'b1;
                  countD = countQ + 16'h0001;
                  stateD = sme_pkg::ST_IDLE;
               end
            end
         end
         sme_pkg::ST_WRITE: begin
            if (memAck) begin
               reqD = 1'b0;
               weD = 1'b0;
               doneD = 1'b1;
               countD = countQ + 16'h0001;
               stateD = sme_pkg::ST_IDLE;
            end
         end
         default: begin
            reqD = 1'b0;
            weD = 1'b0;
            stateD = sme_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stateQ <= sme_pkg::ST_IDLE;
         clsQ <= sme_pkg::CLS_NOP;
         destQ <= 1'b0;
         selQ <= 1'b0;
         relQ <= 1'b0;
         updQ <= 2'h0;
         wQ <= sme_pkg::W_RST;
         carryQ <= 1'b0;
         zeroQ <= 1'b0;
         enQ <= sme_pkg::CTRL_EN_RST;
         ptrQ[0] <= sme_pkg::PTR_RST;
         ptrQ[1] <= sme_pkg::PTR_RST;
         countQ <= 16'h0000;
         reqQ <= 1'b0;
         weQ <= 1'b0;
         addrQ <= 16'h0000;
         wdataQ <= 8'h00;
         doneQ <= 1'b0;
         rdataQ <= 32'h0000_0000;
      end else begin
         stateQ <= stateD;
         clsQ <= clsD;
         destQ <= destD;
         selQ <= selD;
         relQ <= relD;
         updQ <= updD;
         wQ <= wD;
         carryQ <= carryD;
         zeroQ <= zeroD;
         enQ <= enD;
         ptrQ <= ptrD;
         countQ <= countD;
         reqQ <= reqD;
         weQ <= weD;
         addrQ <= addrD;
         wdataQ <= wdataD;
         doneQ <= doneD;
         rdataQ <= rdataD;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   logic rdDone;
   assign rdDone = stateQ == sme_pkg::ST_READ && memAck;

   a_shift_result: assert property (
      rdDone && clsQ == sme_pkg::CLS_SHIFT |=> carryQ == $past(memRdata[0]) &&
         (destQ ? memWdata : wQ) == {1'b0, $past(memRdata[7:1])})
      else $error("shift result or carry wrong");
   a_shift_zero: assert property (
      rdDone && clsQ == sme_pkg::CLS_SHIFT |=> zeroQ == ($past(memRdata[7:1]) == 7'h00))
      else $error("shift zero flag wrong");
   a_to_w_only: assert property (
      rdDone && !destQ |=> !memReq && instrDone && stateQ == sme_pkg::ST_IDLE)
      else $error("result to W still touched memory");
   a_write_back: assert property (
      rdDone && destQ && clsQ != sme_pkg::CLS_INDIR |=> memReq && memWe && $stable(memAddr)
         && $stable(wQ))
      else $error("write back missing");
   a_move_zero: assert property (
      rdDone && clsQ == sme_pkg::CLS_MOVE |=> zeroQ == ($past(memRdata) == 8'h00))
      else $error("move zero flag wrong");
   a_preinc_addr: assert property (
      accept && instrWord[13:12] == sme_pkg::CLS_INDIR && !instrWord[7] &&
         instrWord[1:0] == sme_pkg::UPD_PREINC
         |=> memAddr == $past(ptrQ[instrWord[6]]) + 16'h0001)
      else $error("preincrement address wrong");
   a_rel_keep: assert property (
      rdDone && clsQ == sme_pkg::CLS_INDIR && relQ |=> $stable(ptrQ[selQ]))
      else $error("relative form moved pointer");
   a_ptr_step: assert property (
      rdDone && clsQ == sme_pkg::CLS_INDIR && !relQ |=>
         ptrQ[selQ] == $past(ptrQ[selQ]) + (updQ[0] ? 16'hFFFF : 16'h0001))
      else $error("pointer step wrong");
   a_alias_addr: assert property (
      accept && instrWord[13] != instrWord[12] && instrWord[6:0] == sme_pkg::ALIAS1_ADDR
         |=> memAddr == $past(ptrQ[1]))
      else $error("alias did not follow pointer");
   a_indir_flags: assert property (
      rdDone && clsQ == sme_pkg::CLS_INDIR |=> $stable(carryQ) &&
         zeroQ == ($past(memRdata) == 8'h00) && wQ == $past(memRdata))
      else $error("indirect load flags wrong");
   a_req_hold: assert property (
      memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe))
      else $error("memory request dropped");

   c_shift_back: cover property (rdDone && clsQ == sme_pkg::CLS_SHIFT && destQ);
   c_move_w: cover property (rdDone && clsQ == sme_pkg::CLS_MOVE && !destQ);
   c_postdec: cover property (rdDone && clsQ == sme_pkg::CLS_INDIR && updQ == 2'b11);
   c_wrap: cover property (rdDone && clsQ == sme_pkg::CLS_INDIR && ptrQ[selQ] == 16'hFFFF);
endmodule : sme_exec

//--- verif/sme_mem_model.sv
/*
 * Behavioural file and data memory, 64K bytes, answering each request with
 * a one-cycle memAck, promptly or two cycles late when slow is high.
 * Assumes the exec slice holds memReq, memWe, memAddr and memWdata until memAck.
 */
`timescale 1ns/100ps
module sme_mem_model (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // request side
   input wire logic memReq,
   input wire logic memWe,
   input wire logic [15:0] memAddr,
   input wire logic [7:0] memWdata,
   input wire logic slow,
   output logic memAck,
   output logic [7:0] memRdata
);
   logic [7:0] mem [0:65535];
   logic [1:0] waitQ;
   // read data toggles outside the ack cycle so a stale byte never matches
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         memAck <= 1'b0;
         waitQ <= 2'h0;
         memRdata <= 8'hA5;
      end else if (memReq && !memAck && slow && waitQ != 2'h2) begin
         waitQ <= waitQ + 2'h1;
         memRdata <= ~memRdata;
      end else if (memReq && !memAck) begin
         memAck <= 1'b1;
         waitQ <= 2'h0;
         memRdata <= mem[memAddr];
         if (memWe) mem[memAddr] <= memWdata;
      end else begin
         memAck <= 1'b0;
         memRdata <= ~memRdata;
      end
   end
endmodule : sme_mem_model

//--- verif/tb_shift_move_indirect_exec.sv
/*
 * Self-checking bench for the exec slice: APB register access, instructions
 * from a fetch driver, memory from sme_mem_model.
 * Assumes 10 MHz clock and the register map of sme_pkg.
 */
`timescale 1ns/100ps
module tb_shift_move_indirect_exec;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, slow, er;
   logic instrValid, instrReady, instrDone, memReq, memWe, memAck;
   logic [7:0] paddr, memWdata, memRdata, pofs;
   logic [31:0] pwdata, prdata, rd;
   logic [13:0] instrWord;
   logic [15:0] memAddr;
   int failures, checks, cycles, retired;
   logic [7:0] fld [6] = '{8'h00, 8'h41, 8'h02, 8'h43, 8'hA0, 8'hDF};
   logic [15:0] pv [6] = '{16'hFFFF, 16'h0000, 16'h1234, 16'h2000, 16'h3000, 16'h3000};
   logic [15:0] ea [6] = '{16'h0000, 16'hFFFF, 16'h1234, 16'h2000, 16'h2FE0, 16'h301F};
   logic [15:0] pa [6] = '{16'h0000, 16'hFFFF, 16'h1235, 16'h1FFF, 16'h3000, 16'h3000};
   sme_exec sme_exec_i (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .instrValid, .instrWord, .instrReady, .instrDone, .memReq, .memWe,
      .memAddr, .memWdata, .memAck, .memRdata);
   sme_mem_model sme_mem_model_i (.clk, .resetn, .memReq, .memWe, .memAddr, .memWdata,
      .slow, .memAck, .memRdata);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      check(rd, exp);
   endtask : rdc
   task memc(input logic [15:0] a, input logic [7:0] e);
      check({24'h000000, sme_mem_model_i.mem[a]}, {24'h000000, e});
   endtask : memc
   task exec(input logic [13:0] w);
      @(posedge clk);
      instrValid <= 1'b1;
      instrWord <= w;
      do @(posedge clk); while (instrReady !== 1'b1);
      instrValid <= 1'b0;
      retired++;
      do @(posedge clk); while (instrDone !== 1'b1);
   endtask : exec
   task finish_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   initial begin
      {resetn, psel, penable, pwrite, instrValid, slow} = 6'h00;
      {paddr, pwdata, instrWord} = '0;
      {failures, checks, cycles, retired} = '0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rdc(sme_pkg::OFF_CTRL, 32'h00000001);
      rdc(sme_pkg::OFF_W, 32'h00000000);
      rdc(sme_pkg::OFF_STAT, 32'h00000000);
      rdc(sme_pkg::OFF_PTR0, 32'h00000000);
      rdc(sme_pkg::OFF_COUNT, 32'h00000000);
      rdc(8'h18, 32'h00000000);
      check({31'h0, er}, 32'h00000001);
      // shift to W, then shift back into file 127 with slow memory
      sme_mem_model_i.mem[16'h0010] = 8'h81;
      exec(14'h1010);
      rdc(sme_pkg::OFF_W, 32'h00000040);
      rdc(sme_pkg::OFF_STAT, 32'h00000001);
      memc(16'h0010, 8'h81);
      sme_mem_model_i.mem[16'h007F] = 8'h01;
      slow <= 1'b1;
      exec(14'h10FF);
      slow <= 1'b0;
      memc(16'h007F, 8'h00);
      rdc(sme_pkg::OFF_STAT, 32'h00000003);
      rdc(sme_pkg::OFF_W, 32'h00000040);
      sme_mem_model_i.mem[16'h0020] = 8'h00;
      exec(14'h2020);
      rdc(sme_pkg::OFF_W, 32'h00000000);
      rdc(sme_pkg::OFF_STAT, 32'h00000003);
      sme_mem_model_i.mem[16'h0021] = 8'h5A;
      exec(14'h20A1);
      rdc(sme_pkg::OFF_STAT, 32'h00000001);
      memc(16'h0021, 8'h5A);
      rdc(sme_pkg::OFF_W, 32'h00000000);
      // four instructions so far, each retired once
      rdc(sme_pkg::OFF_COUNT, 32'h00000004);
      // every update mode and both offset ends, both pointers
      for (int i = 0; i < 6; i++) begin
         pofs = fld[i][6] ? sme_pkg::OFF_PTR1 : sme_pkg::OFF_PTR0;
         apb(1'b1, pofs, {16'h0000, pv[i]});
         sme_mem_model_i.mem[ea[i]] = 8'(i * 17);
         apb(1'b1, sme_pkg::OFF_STAT, 32'h00000001);
         exec({6'h30, fld[i]});
         rdc(sme_pkg::OFF_W, 32'(i * 17));
         rdc(pofs, {16'h0000, pa[i]});
         rdc(sme_pkg::OFF_STAT, i == 0 ? 32'h00000003 : 32'h00000001);
      end
      // alias addresses go through the pointers
      apb(1'b1, sme_pkg::OFF_PTR1, 32'h00004444);
      sme_mem_model_i.mem[16'h4444] = 8'h77;
      exec(14'h2001);
      rdc(sme_pkg::OFF_W, 32'h00000077);
      apb(1'b1, sme_pkg::OFF_PTR0, 32'h00005555);
      sme_mem_model_i.mem[16'h5555] = 8'h02;
      exec(14'h1080);
      memc(16'h5555, 8'h01);
      // disabled slice refuses instructions
      apb(1'b1, sme_pkg::OFF_CTRL, 32'h00000000);
      instrValid <= 1'b1;
      instrWord <= 14'h2020;
      repeat (3) @(posedge clk);
      check({31'h0, instrReady}, 32'h00000000);
      check({31'h0, memReq}, 32'h00000000);
      instrValid <= 1'b0;
      apb(1'b1, sme_pkg::OFF_CTRL, 32'h00000001);
      rdc(sme_pkg::OFF_COUNT, 32'(retired));
      finish_test();
   end
endmodule : tb_shift_move_indirect_exec
